// ### hdl/rsa_pkg.sv
// constants for the remote settings access block
package rsa_pkg;
  // word addresses and zone word count of the register window
  localparam logic [15:0] ZONE_BASE   = 16'h2000;
  localparam logic [15:0] ZONE_LAST   = 16'h207C;
  localparam logic [15:0] RDREQ_ADDR  = 16'h2080;
  localparam logic [15:0] WRBLK_BASE  = 16'h2100;
  localparam logic [6:0]  ZONE_WORDS  = 7'h7D;
  // modbus function codes
  localparam logic [7:0]  FC_READ     = 8'h03;
  localparam logic [7:0]  FC_WR_ONE   = 8'h06;
  localparam logic [7:0]  FC_WR_MANY  = 8'h10;
  // exception codes, zero means normal reply
  localparam logic [7:0]  EXC_NONE    = 8'h00;
  localparam logic [7:0]  EXC_FUNC    = 8'h01;
  localparam logic [7:0]  EXC_ADDR    = 8'h02;
  localparam logic [7:0]  EXC_VALUE   = 8'h03;
  localparam logic [7:0]  EXC_NACK    = 8'h07;
  // reply header values
  localparam logic [15:0] HDR_RESET   = 16'h0000;
  localparam logic [15:0] HDR_PENDING = 16'hFFFF;
  localparam logic [7:0]  RELAY_BAD   = 8'hFF;
  // reply source regions
  localparam logic [1:0]  REG_ZONE    = 2'h0;
  localparam logic [1:0]  REG_RDREQ   = 2'h1;
  localparam logic [1:0]  REG_WRBLK   = 2'h2;
  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_RDOUT = 4'h2,
    S_WRIN  = 4'h4,
    S_DONE  = 4'h8
  } state_t;
endpackage : rsa_pkg

// ### hdl/remote_settings_access.sv
// remote settings read and write window behind a modbus slave
`timescale 1ns/1ps
`default_nettype none
module remote_settings_access #(
  parameter int MAX_RELAYS = 2
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // modbus transaction side
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_func_i,
  input  wire logic [15:0] cmd_addr_i,
  input  wire logic [6:0]  cmd_qty_i,
  input  wire logic        wr_valid_i,
  input  wire logic [15:0] wr_data_i,
  output logic             rd_valid_o,
  output logic [15:0]      rd_data_o,
  output logic             done_o,
  output logic [7:0]       exc_code_o,
  // settings engine side
  input  wire logic        set_inhibit_i,
  output logic             job_valid_o,
  output logic             job_write_o,
  output logic [15:0]      job_word_o,
  input  wire logic        job_ready_i,
  input  wire logic [6:0]  blk_idx_i,
  output logic [15:0]      blk_data_o,
  input  wire logic        res_wr_i,
  input  wire logic [6:0]  res_idx_i,
  input  wire logic [15:0] res_data_i,
  input  wire logic        res_done_i,
  input  wire logic        res_ok_i,
  input  wire logic [6:0]  res_len_i,
  // status
  output logic             busy_o
);
  localparam logic [7:0] MAX_REL = 8'(MAX_RELAYS);

  rsa_pkg::state_t state_ff, nxt_state;
  logic [6:0]  cnt_ff, nxt_cnt, qty_ff, nxt_qty, len_ff, nxt_len;
  logic [1:0]  region_ff, nxt_region;
  logic [7:0]  exc_ff, nxt_exc, exc_code_ff, nxt_exc_code;
  logic        acc_ff, nxt_acc, busy_ff, nxt_busy;
  logic        job_valid_ff, nxt_job_valid, job_write_ff, nxt_job_write;
  logic [15:0] job_word_ff, nxt_job_word, rdreq_ff, nxt_rdreq;
  logic        rd_valid_ff, nxt_rd_valid, done_ff, nxt_done;
  logic [15:0] rd_data_ff, nxt_rd_data, blk_data_ff, nxt_blk_data;
  logic [15:0] zone_ff [0:124];
  logic [15:0] nxt_zone [0:124];
  logic [15:0] blk_ff [0:124];
  logic [15:0] nxt_blk [0:124];

  function automatic logic bcd_ok(input logic [7:0] fc);
    bcd_ok = (fc[7:4] <= 4'h9) && (fc[3:0] <= 4'h9) && (fc != 8'h00);
  endfunction : bcd_ok

  logic [6:0]  wqty;
  logic [15:0] hw;
  logic        hw_ok;

  always_comb begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff;
    nxt_qty       = qty_ff;
    nxt_len       = len_ff;
    nxt_region    = region_ff;
    nxt_exc       = exc_ff;
    nxt_exc_code  = exc_code_ff;
    nxt_acc       = acc_ff;
    nxt_busy      = busy_ff;
    nxt_job_valid = job_valid_ff;
    nxt_job_write = job_write_ff;
    nxt_job_word  = job_word_ff;
    nxt_rdreq     = rdreq_ff;
    nxt_rd_valid  = 1'b0;
    nxt_rd_data   = rd_data_ff;
    nxt_done      = 1'b0;
    wqty          = 7'h00;
    hw            = 16'h0000;
    hw_ok         = 1'b0;
    for (int i = 0; i < 125; i++) begin
      nxt_zone[i] = zone_ff[i];
      nxt_blk[i]  = blk_ff[i];
    end
    nxt_blk_data = (blk_idx_i < rsa_pkg::ZONE_WORDS) ? blk_ff[blk_idx_i] : 16'h0000;
    if (job_valid_ff && job_ready_i) begin
      nxt_job_valid = 1'b0;
    end
    // engine results only count while a job is open
    if (busy_ff && res_wr_i && res_idx_i != 7'h00 && res_idx_i < rsa_pkg::ZONE_WORDS) begin
      nxt_zone[res_idx_i] = res_data_i;
    end
    if (busy_ff && res_done_i) begin
      nxt_busy      = 1'b0;
      nxt_job_valid = 1'b0;
      if (res_ok_i) begin
        nxt_zone[0] = job_word_ff;
        if (res_len_i != 7'h00 && res_len_i <= rsa_pkg::ZONE_WORDS) begin
          nxt_len = res_len_i;
        end
      end else begin
        nxt_zone[0] = {job_word_ff[15:8], rsa_pkg::RELAY_BAD};
      end
    end
    unique case (state_ff)
      rsa_pkg::S_IDLE: begin
        nxt_cnt = 7'h00;
        nxt_exc = rsa_pkg::EXC_NONE;
        nxt_acc = 1'b0;
        if (cmd_valid_i) begin
          nxt_qty   = cmd_qty_i;
          nxt_state = rsa_pkg::S_DONE;
          if (cmd_func_i == rsa_pkg::FC_READ) begin
            if (cmd_qty_i == 7'h00 || cmd_qty_i > rsa_pkg::ZONE_WORDS) begin
              nxt_exc = rsa_pkg::EXC_VALUE;
            end else if (cmd_addr_i == rsa_pkg::ZONE_BASE) begin
              nxt_region = rsa_pkg::REG_ZONE;
              if (cmd_qty_i == 7'h01 || cmd_qty_i == rsa_pkg::ZONE_WORDS || cmd_qty_i == len_ff) begin
                nxt_state = rsa_pkg::S_RDOUT;
              end else begin
                nxt_exc = rsa_pkg::EXC_VALUE;
              end
            end else if (cmd_addr_i == rsa_pkg::RDREQ_ADDR && cmd_qty_i == 7'h01) begin
              nxt_region = rsa_pkg::REG_RDREQ;
              nxt_state  = rsa_pkg::S_RDOUT;
            end else if (cmd_addr_i == rsa_pkg::WRBLK_BASE) begin
              nxt_region = rsa_pkg::REG_WRBLK;
              nxt_state  = rsa_pkg::S_RDOUT;
            end else begin
              nxt_exc = rsa_pkg::EXC_ADDR;
            end
          end else if (cmd_func_i == rsa_pkg::FC_WR_ONE || cmd_func_i == rsa_pkg::FC_WR_MANY) begin
            wqty      = (cmd_func_i == rsa_pkg::FC_WR_ONE) ? 7'h01 : cmd_qty_i;
            nxt_qty   = wqty;
            nxt_state = rsa_pkg::S_WRIN;
            // refused writes still drain their words before the reply, except a bad quantity, which replies at once
            if (wqty == 7'h00 || wqty > rsa_pkg::ZONE_WORDS) begin
              nxt_exc   = rsa_pkg::EXC_VALUE;
              nxt_state = rsa_pkg::S_DONE;
            end else if (cmd_addr_i == rsa_pkg::RDREQ_ADDR && wqty == 7'h01) begin
              nxt_region = rsa_pkg::REG_RDREQ;
              nxt_exc    = busy_ff ? rsa_pkg::EXC_NACK : rsa_pkg::EXC_NONE;
            end else if (cmd_addr_i == rsa_pkg::WRBLK_BASE && cmd_func_i == rsa_pkg::FC_WR_MANY) begin
              nxt_region = rsa_pkg::REG_WRBLK;
              nxt_exc    = (busy_ff || set_inhibit_i) ? rsa_pkg::EXC_NACK : rsa_pkg::EXC_NONE;
            end else begin
              nxt_exc = rsa_pkg::EXC_ADDR;
            end
            nxt_acc = (nxt_exc == rsa_pkg::EXC_NONE);
          end else begin
            nxt_exc = rsa_pkg::EXC_FUNC;
          end
        end
      end
      rsa_pkg::S_RDOUT: begin
        nxt_rd_valid = 1'b1;
        case (region_ff)
          rsa_pkg::REG_ZONE:  nxt_rd_data = zone_ff[cnt_ff];
          rsa_pkg::REG_RDREQ: nxt_rd_data = rdreq_ff;
          default:            nxt_rd_data = blk_ff[cnt_ff];
        endcase
        nxt_cnt = cnt_ff + 7'h01;
        if (cnt_ff == qty_ff - 7'h01) begin
          nxt_state = rsa_pkg::S_DONE;
        end
      end
      rsa_pkg::S_WRIN: begin
        if (wr_valid_i) begin
          nxt_cnt = cnt_ff + 7'h01;
          if (acc_ff) begin
            if (region_ff == rsa_pkg::REG_RDREQ) begin
              nxt_rdreq = wr_data_i;
            end else begin
              nxt_blk[cnt_ff] = wr_data_i;
            end
          end
          if (cnt_ff == qty_ff - 7'h01) begin
            nxt_state = rsa_pkg::S_DONE;
            if (acc_ff) begin
              hw = (cnt_ff == 7'h00) ? wr_data_i : blk_ff[0];
              if (region_ff == rsa_pkg::REG_RDREQ) begin
                hw_ok = bcd_ok(hw[15:8]) && (hw[7:0] <= MAX_REL);
              end else begin
                hw_ok = bcd_ok(hw[15:8]) && (hw[7:0] != 8'h00) && (hw[7:0] <= MAX_REL);
              end
              if (hw_ok) begin
                nxt_zone[0]   = rsa_pkg::HDR_PENDING;
                nxt_busy      = 1'b1;
                nxt_job_valid = 1'b1;
                nxt_job_write = (region_ff == rsa_pkg::REG_WRBLK);
                nxt_job_word  = hw;
              end else begin
                // bad code never reaches the engine
                nxt_zone[0] = {hw[15:8], rsa_pkg::RELAY_BAD};
              end
            end
          end
        end
      end
      rsa_pkg::S_DONE: begin
        nxt_done     = 1'b1;
        nxt_exc_code = exc_ff;
        nxt_state    = rsa_pkg::S_IDLE;
      end
      default: nxt_state = rsa_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_ff     <= rsa_pkg::S_IDLE;
      cnt_ff       <= 7'h00;
      qty_ff       <= 7'h00;
      len_ff       <= rsa_pkg::ZONE_WORDS;
      region_ff    <= rsa_pkg::REG_ZONE;
      exc_ff       <= rsa_pkg::EXC_NONE;
      exc_code_ff  <= rsa_pkg::EXC_NONE;
      acc_ff       <= 1'b0;
      busy_ff      <= 1'b0;
      job_valid_ff <= 1'b0;
      job_write_ff <= 1'b0;
      job_word_ff  <= 16'h0000;
      rdreq_ff     <= 16'h0000;
      rd_valid_ff  <= 1'b0;
      rd_data_ff   <= 16'h0000;
      done_ff      <= 1'b0;
      blk_data_ff  <= 16'h0000;
      for (int i = 0; i < 125; i++) begin
        zone_ff[i] <= rsa_pkg::HDR_RESET;
        blk_ff[i]  <= 16'h0000;
      end
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      qty_ff       <= nxt_qty;
      len_ff       <= nxt_len;
      region_ff    <= nxt_region;
      exc_ff       <= nxt_exc;
      exc_code_ff  <= nxt_exc_code;
      acc_ff       <= nxt_acc;
      busy_ff      <= nxt_busy;
      job_valid_ff <= nxt_job_valid;
      job_write_ff <= nxt_job_write;
      job_word_ff  <= nxt_job_word;
      rdreq_ff     <= nxt_rdreq;
      rd_valid_ff  <= nxt_rd_valid;
      rd_data_ff   <= nxt_rd_data;
      done_ff      <= nxt_done;
      blk_data_ff  <= nxt_blk_data;
      for (int i = 0; i < 125; i++) begin
        zone_ff[i] <= nxt_zone[i];
        blk_ff[i]  <= nxt_blk[i];
      end
    end
  end

  assign rd_valid_o  = rd_valid_ff;
  assign rd_data_o   = rd_data_ff;
  assign done_o      = done_ff;
  assign exc_code_o  = exc_code_ff;
  assign job_valid_o = job_valid_ff;
  assign job_write_o = job_write_ff;
  assign job_word_o  = job_word_ff;
  assign blk_data_o  = blk_data_ff;
  assign busy_o      = busy_ff;

  property p_hdr_reset;
    @(posedge mclk_i) $past(!rst_n_i) |-> zone_ff[0] == rsa_pkg::HDR_RESET;
  endproperty
  a_hdr_reset: assert property (p_hdr_reset) else $error("header not clear after reset");
  property p_rd_busy;
    @(posedge mclk_i) disable iff (!rst_n_i)
      state_ff == rsa_pkg::S_IDLE && cmd_valid_i && busy_ff && cmd_func_i == rsa_pkg::FC_WR_ONE
      && cmd_addr_i == rsa_pkg::RDREQ_ADDR |=> exc_ff == rsa_pkg::EXC_NACK && !acc_ff
      ##[1:8] done_ff && exc_code_ff == rsa_pkg::EXC_NACK;
  endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("busy read request not refused");
  property p_wr_inhibit;
    @(posedge mclk_i) disable iff (!rst_n_i)
      state_ff == rsa_pkg::S_IDLE && cmd_valid_i && set_inhibit_i && cmd_func_i == rsa_pkg::FC_WR_MANY
      && cmd_addr_i == rsa_pkg::WRBLK_BASE && cmd_qty_i != 7'h00 && cmd_qty_i <= rsa_pkg::ZONE_WORDS
      |=> exc_ff == rsa_pkg::EXC_NACK && !acc_ff;
  endproperty
  a_wr_inhibit: assert property (p_wr_inhibit) else $error("inhibited write not refused");
  property p_zone_addr;
    @(posedge mclk_i) disable iff (!rst_n_i)
      state_ff == rsa_pkg::S_IDLE && cmd_valid_i && cmd_func_i == rsa_pkg::FC_READ && cmd_qty_i == 7'h01
      && cmd_addr_i > rsa_pkg::ZONE_BASE && cmd_addr_i <= rsa_pkg::ZONE_LAST
      |-> ##2 done_ff && exc_code_ff == rsa_pkg::EXC_ADDR;
  endproperty
  a_zone_addr: assert property (p_zone_addr) else $error("mid-zone read not refused");
  property p_pending;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $rose(busy_ff) |-> zone_ff[0] == rsa_pkg::HDR_PENDING && job_valid_ff;
  endproperty
  a_pending: assert property (p_pending) else $error("header not pending on accept");
  property p_valid_echo;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $fell(busy_ff) && $past(res_ok_i) |-> zone_ff[0] == job_word_ff;
  endproperty
  a_valid_echo: assert property (p_valid_echo) else $error("header does not echo request");
  property p_bad_func;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $fell(busy_ff) && !$past(res_ok_i) |-> zone_ff[0] == {job_word_ff[15:8], rsa_pkg::RELAY_BAD};
  endproperty
  a_bad_func: assert property (p_bad_func) else $error("invalid function not flagged");
  property p_test_read;
    @(posedge mclk_i) disable iff (!rst_n_i)
      state_ff == rsa_pkg::S_IDLE && cmd_valid_i && cmd_func_i == rsa_pkg::FC_READ
      && cmd_addr_i == rsa_pkg::ZONE_BASE && cmd_qty_i == 7'h01 && !busy_ff
      |-> ##2 rd_valid_ff && rd_data_ff == $past(zone_ff[0], 2) ##1 done_ff && exc_code_ff == rsa_pkg::EXC_NONE;
  endproperty
  a_test_read: assert property (p_test_read) else $error("validity read failed");
endmodule : remote_settings_access
`default_nettype wire

// ### testbench/settings_engine_model.sv
// behavioural model of the settings engine behind the block
`timescale 1ns/1ps
`default_nettype none
module settings_engine_model #(
  parameter int DELAY = 20
) (
  // clock
  input  wire logic        mclk_i,
  // job from the block
  input  wire logic        job_valid_i,
  input  wire logic        job_write_i,
  input  wire logic [15:0] job_word_i,
  input  wire logic [15:0] blk_data_i,
  // answers to the block
  output logic             job_ready_o,
  output logic [6:0]       blk_idx_o,
  output logic             res_wr_o,
  output logic [6:0]       res_idx_o,
  output logic [15:0]      res_data_o,
  output logic             res_done_o,
  output logic             res_ok_o,
  output logic [6:0]       res_len_o
);
  logic [15:0] w;
  logic        wr;
  initial begin
    {job_ready_o, res_wr_o, res_done_o, res_ok_o} = 4'h0;
    blk_idx_o = 7'h00;
    res_idx_o = 7'h00;
    res_data_o = 16'h0000;
    res_len_o = 7'h00;
    forever begin
      @(negedge mclk_i);
      if (job_valid_i === 1'b1) begin
        w = job_word_i;
        wr = job_write_i;
        job_ready_o = 1'b1;
        @(negedge mclk_i);
        job_ready_o = 1'b0;
        blk_idx_o = 7'h01;
        // slow background cycle, never answers at once
        repeat (DELAY) @(negedge mclk_i);
        res_wr_o = 1'b1;
        res_idx_o = 7'h01;
        res_data_o = wr ? blk_data_i : {w[7:0], w[15:8]};
        @(negedge mclk_i);
        res_wr_o = 1'b0;
        res_done_o = 1'b1;
        res_ok_o = (w[15:8] !== 8'h55);
        res_len_o = 7'h03;
        @(negedge mclk_i);
        res_done_o = 1'b0;
        // released lines must not keep the last word
        res_data_o = ~res_data_o;
        res_idx_o = 7'h7F;
      end
    end
  end
endmodule : settings_engine_model
`default_nettype wire

// ### testbench/remote_settings_access_tb_top.sv
// self-checking bench for the remote settings access block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module remote_settings_access_tb_top;
  logic        mclk_i, rst_n_i, cmd_valid_i, wr_valid_i, set_inhibit_i;
  logic        rd_valid_o, done_o, job_valid_o, job_write_o, busy_o;
  logic        job_ready_i, res_wr_i, res_done_i, res_ok_i;
  logic [7:0]  cmd_func_i, exc_code_o, exc;
  logic [15:0] cmd_addr_i, wr_data_i, rd_data_o, job_word_o, blk_data_o, res_data_i;
  logic [6:0]  cmd_qty_i, blk_idx_i, res_idx_i, res_len_i;
  logic [15:0] wbuf [0:2];
  logic [15:0] rbuf [0:2];
  int          n_errors, checks_done;

  remote_settings_access #(.MAX_RELAYS(2)) uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_func_i(cmd_func_i), .cmd_addr_i(cmd_addr_i),
    .cmd_qty_i(cmd_qty_i), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .done_o(done_o), .exc_code_o(exc_code_o),
    .set_inhibit_i(set_inhibit_i), .job_valid_o(job_valid_o), .job_write_o(job_write_o),
    .job_word_o(job_word_o), .job_ready_i(job_ready_i), .blk_idx_i(blk_idx_i),
    .blk_data_o(blk_data_o), .res_wr_i(res_wr_i), .res_idx_i(res_idx_i),
    .res_data_i(res_data_i), .res_done_i(res_done_i), .res_ok_i(res_ok_i),
    .res_len_i(res_len_i), .busy_o(busy_o));

  settings_engine_model #(.DELAY(20)) engine (.mclk_i(mclk_i), .job_valid_i(job_valid_o),
    .job_write_i(job_write_o), .job_word_i(job_word_o), .blk_data_i(blk_data_o),
    .job_ready_o(job_ready_i), .blk_idx_o(blk_idx_i), .res_wr_o(res_wr_i),
    .res_idx_o(res_idx_i), .res_data_o(res_data_i), .res_done_o(res_done_i),
    .res_ok_o(res_ok_i), .res_len_o(res_len_i));

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // one modbus transaction; nw words from wbuf, first three read words kept
  task automatic mb(input logic [7:0] f, input logic [15:0] a, input logic [6:0] q, input int nw);
    int i;
    int k;
    logic seen;
    k = 0;
    seen = 1'b0;
    // stale words from an earlier read must not pass a check
    for (i = 0; i < 3; i++) rbuf[i] = 16'hXXXX;
    @(negedge mclk_i);
    {cmd_valid_i, cmd_func_i, cmd_addr_i, cmd_qty_i} = {1'b1, f, a, q};
    @(negedge mclk_i);
    cmd_valid_i = 1'b0;
    for (i = 0; i < nw; i++) begin
      wr_valid_i = 1'b1;
      wr_data_i = wbuf[i];
      @(negedge mclk_i);
    end
    wr_valid_i = 1'b0;
    wr_data_i = ~wr_data_i;
    repeat (200) begin
      @(posedge mclk_i);
      #1;
      if (rd_valid_o === 1'b1 && k < 3) rbuf[k] = rd_data_o;
      if (rd_valid_o === 1'b1) k++;
      if (done_o === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
    `CHK(seen, 1'b1)
    exc = exc_code_o;
  endtask : mb

  task automatic rd(input logic [15:0] a, input logic [6:0] q);
    mb(rsa_pkg::FC_READ, a, q, 0);
  endtask : rd

  task automatic wrq(input logic [15:0] w);
    wbuf[0] = w;
    mb(rsa_pkg::FC_WR_ONE, rsa_pkg::RDREQ_ADDR, 7'h01, 1);
  endtask : wrq

  task automatic wr_blk(input logic [15:0] h);
    wbuf[0] = h;
    mb(rsa_pkg::FC_WR_MANY, rsa_pkg::WRBLK_BASE, 7'h03, 3);
  endtask : wr_blk

  task automatic wait_idle;
    repeat (200) begin
      @(posedge mclk_i);
      #1;
      if (busy_o === 1'b0) break;
    end
    `CHK(busy_o, 1'b0)
  endtask : wait_idle

  task automatic t_power_up;
    rd(rsa_pkg::ZONE_BASE, 7'h01);
    `CHK(exc, rsa_pkg::EXC_NONE)
    `CHK(rbuf[0], rsa_pkg::HDR_RESET)
    $display("test power_up done");
  endtask : t_power_up

  task automatic t_read;
    wrq(16'h1001);
    `CHK(exc, rsa_pkg::EXC_NONE)
    rd(rsa_pkg::ZONE_BASE, 7'h01);
    `CHK(rbuf[0], rsa_pkg::HDR_PENDING)
    wrq(16'h2002);
    `CHK(exc, rsa_pkg::EXC_NACK)
    rd(rsa_pkg::RDREQ_ADDR, 7'h01);
    `CHK(rbuf[0], 16'h1001)
    wait_idle();
    rd(rsa_pkg::ZONE_BASE, 7'h03);
    `CHK(exc, rsa_pkg::EXC_NONE)
    `CHK(rbuf[0], 16'h1001)
    `CHK(rbuf[1], 16'h0110)
    rd(rsa_pkg::ZONE_BASE, rsa_pkg::ZONE_WORDS);
    `CHK(exc, rsa_pkg::EXC_NONE)
    rd(rsa_pkg::ZONE_BASE + 16'h0001, 7'h01);
    `CHK(exc, rsa_pkg::EXC_ADDR)
    rd(rsa_pkg::ZONE_BASE, 7'h02);
    `CHK(exc, rsa_pkg::EXC_VALUE)
    // a code outside bcd never reaches the engine
    wrq(16'hA101);
    wait_idle();
    rd(rsa_pkg::ZONE_BASE, 7'h01);
    `CHK(rbuf[0], 16'hA1FF)
    // read request through a one-word multiple write
    wbuf[0] = 16'h1002;
    mb(rsa_pkg::FC_WR_MANY, rsa_pkg::RDREQ_ADDR, 7'h01, 1);
    `CHK(exc, rsa_pkg::EXC_NONE)
    wait_idle();
    rd(rsa_pkg::ZONE_BASE, 7'h01);
    `CHK(rbuf[0], 16'h1002)
    mb(8'h04, rsa_pkg::ZONE_BASE, 7'h01, 0);
    `CHK(exc, rsa_pkg::EXC_FUNC)
    $display("test read done");
  endtask : t_read

  task automatic t_write;
    wbuf[1] = 16'h1234;
    wbuf[2] = 16'h5678;
    @(negedge mclk_i);
    set_inhibit_i = 1'b1;
    wr_blk(16'h0502);
    `CHK(exc, rsa_pkg::EXC_NACK)
    @(negedge mclk_i);
    set_inhibit_i = 1'b0;
    wr_blk(16'h0502);
    `CHK(exc, rsa_pkg::EXC_NONE)
    rd(rsa_pkg::WRBLK_BASE, 7'h03);
    `CHK(rbuf[0], 16'h0502)
    `CHK(rbuf[2], 16'h5678)
    wr_blk(16'h0501);
    `CHK(exc, rsa_pkg::EXC_NACK)
    wait_idle();
    rd(rsa_pkg::ZONE_BASE, 7'h03);
    `CHK(exc, rsa_pkg::EXC_NONE)
    `CHK(rbuf[0], 16'h0502)
    `CHK(rbuf[1], 16'h1234)
    wr_blk(16'h5501);
    wait_idle();
    rd(rsa_pkg::ZONE_BASE, 7'h01);
    `CHK(rbuf[0], 16'h55FF)
    wr_blk(16'h0500);
    wait_idle();
    rd(rsa_pkg::ZONE_BASE, 7'h01);
    `CHK(rbuf[0], 16'h05FF)
    $display("test write done");
  endtask : t_write

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // the tests need a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    print_verdict();
  end

  initial begin
    n_errors = 0;
    checks_done = 0;
    {rst_n_i, cmd_valid_i, wr_valid_i, set_inhibit_i} = 4'h0;
    cmd_func_i = 8'h00;
    cmd_addr_i = 16'h0000;
    cmd_qty_i = 7'h00;
    wr_data_i = 16'h0000;
    repeat (4) @(negedge mclk_i);
    rst_n_i = 1'b1;
    t_power_up();
    t_read();
    t_write();
    print_verdict();
  end
endmodule : remote_settings_access_tb_top
`default_nettype wire
